// [pkg/cpf_pkg.sv]
`default_nettype none
package cpf_pkg;
  // Reset values and memory layout (word addresses for flash)
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [15:0] SP_RESET    = 16'h2FFF;
  localparam logic [7:0]  SREG_RESET  = 8'h00;
  localparam logic [15:0] TBL_LO      = 16'h7800;
  localparam logic [15:0] BOOT_LO     = 16'h8000;
  localparam logic [15:0] BOOT_HI     = 16'h87FF;
  localparam logic [7:0]  LOCKED_READ = 8'hFF;
  // Pointer pairs: low register index of each
  localparam int X_LO = 26;
  localparam int Y_LO = 28;
  localparam int Z_LO = 30;
  // Opcode field, bits 15:12
  localparam logic [3:0] OP_MISC  = 4'h0;
  localparam logic [3:0] OP_LDI   = 4'h8;
  localparam logic [3:0] OP_SUBI  = 4'h9;
  localparam logic [3:0] OP_ANDI  = 4'hA;
  localparam logic [3:0] OP_ORI   = 4'hB;
  localparam logic [3:0] OP_ADIW  = 4'hC;
  localparam logic [3:0] OP_LDST  = 4'hD;
  localparam logic [3:0] OP_INOUT = 4'hE;
  localparam logic [3:0] OP_FLOW  = 4'hF;
  localparam logic [3:0] OP_MUL   = 4'h7;
  // Function field of the misc group, bits 3:0
  localparam logic [3:0] FN_RET  = 4'h1;
  localparam logic [3:0] FN_RETI = 4'h2;
  localparam logic [3:0] FN_SPM  = 4'h3;
  localparam logic [3:0] FN_LPM  = 4'h4;
  localparam logic [3:0] FN_SEI  = 4'h5;
  localparam logic [3:0] FN_CLI  = 4'h6;
  // Flow kinds, bits 11:10
  localparam logic [1:0] FL_JMP  = 2'h0;
  localparam logic [1:0] FL_CALL = 2'h1;
  localparam logic [1:0] FL_BR   = 2'h2;
  // I/O addresses handled inside the core
  localparam logic [5:0] IO_SPL  = 6'h3D;
  localparam logic [5:0] IO_SPH  = 6'h3E;
  localparam logic [5:0] IO_SREG = 6'h3F;
  // Status flag positions
  localparam int F_C = 0;
  localparam int F_Z = 1;
  localparam int F_N = 2;
  localparam int F_V = 3;
  localparam int F_S = 4;
  localparam int F_H = 5;
  localparam int F_I = 7;
  typedef enum logic [3:0] {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_EOR, ALU_PASS,
                            ALU_ADIW, ALU_MULU, ALU_MULS, ALU_FMUL, ALU_FMULS} cpf_alu_e;
endpackage
`default_nettype wire

// [verilog/cpf_regfile.sv]
`timescale 1ns/100ps
`default_nettype none
module cpf_regfile (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Read ports
  input  wire logic [4:0]  ra_i,
  input  wire logic [4:0]  rb_i,
  output logic      [7:0]  a_o,
  output logic      [7:0]  b_o,
  output logic      [15:0] x_o,
  output logic      [15:0] y_o,
  output logic      [15:0] z_o,
  // Byte and pair write ports
  input  wire logic        we_i,
  input  wire logic [4:0]  waddr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        pwe_i,
  input  wire logic [3:0]  paddr_i,
  input  wire logic [15:0] pdata_i
);
  logic [7:0] regs [32];
  for (genvar i = 0; i < 32; i++) begin : g_reg
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) regs[i] <= 8'h00;
      else if (pwe_i && paddr_i == 4'(i / 2)) regs[i] <= pdata_i[8 * (i % 2) +: 8];
      else if (we_i && waddr_i == 5'(i)) regs[i] <= wdata_i;
    end
  end
  assign a_o = regs[ra_i];
  assign b_o = regs[rb_i];
  assign x_o = {regs[cpf_pkg::X_LO + 1], regs[cpf_pkg::X_LO]};
  assign y_o = {regs[cpf_pkg::Y_LO + 1], regs[cpf_pkg::Y_LO]};
  assign z_o = {regs[cpf_pkg::Z_LO + 1], regs[cpf_pkg::Z_LO]};
endmodule // cpf_regfile
`default_nettype wire

// [verilog/cpf_alu.sv]
`timescale 1ns/100ps
`default_nettype none
module cpf_alu (
  // Operation and operands; for pair ops a is low byte, b high byte
  input  wire cpf_pkg::cpf_alu_e op_i,
  input  wire logic [7:0]        a_i,
  input  wire logic [7:0]        b_i,
  input  wire logic [5:0]        k_i,
  input  wire logic [7:0]        flags_i,
  // Result and flags
  output logic      [15:0]       res_o,
  output logic      [7:0]        flags_o
);
  logic [8:0]         sum8;
  logic [8:0]         dif8;
  logic [16:0]        sum16;
  logic               sgn;
  logic               frac;
  logic signed [17:0] prod;
  logic [15:0]        mres;
  logic               r7;
  logic               wide;
  assign sum8  = {1'b0, a_i} + {1'b0, b_i};
  assign dif8  = {1'b0, a_i} - {1'b0, b_i};
  assign sum16 = {1'b0, b_i, a_i} + {11'h000, k_i};
  assign sgn   = op_i == cpf_pkg::ALU_MULS || op_i == cpf_pkg::ALU_FMULS;
  assign frac  = op_i == cpf_pkg::ALU_FMUL || op_i == cpf_pkg::ALU_FMULS;
  assign prod  = $signed({sgn & a_i[7], a_i}) * $signed({sgn & b_i[7], b_i});
  assign mres  = frac ? {prod[14:0], 1'b0} : prod[15:0];
  assign wide  = op_i == cpf_pkg::ALU_ADIW;
  always_comb begin
    res_o   = 16'h0000;
    flags_o = flags_i;
    case (op_i)
      cpf_pkg::ALU_ADD: begin
        res_o = {8'h00, sum8[7:0]};
        flags_o[cpf_pkg::F_C] = sum8[8];
        flags_o[cpf_pkg::F_H] = (a_i[3] & b_i[3]) | (b_i[3] & ~sum8[3]) | (~sum8[3] & a_i[3]);
        flags_o[cpf_pkg::F_V] = (a_i[7] & b_i[7] & ~sum8[7]) | (~a_i[7] & ~b_i[7] & sum8[7]);
      end
      cpf_pkg::ALU_SUB: begin
        res_o = {8'h00, dif8[7:0]};
        flags_o[cpf_pkg::F_C] = dif8[8];
        flags_o[cpf_pkg::F_H] = (~a_i[3] & b_i[3]) | (b_i[3] & dif8[3]) | (dif8[3] & ~a_i[3]);
        flags_o[cpf_pkg::F_V] = (a_i[7] & ~b_i[7] & ~dif8[7]) | (~a_i[7] & b_i[7] & dif8[7]);
      end
      cpf_pkg::ALU_AND: res_o = {8'h00, a_i & b_i};
      cpf_pkg::ALU_OR:  res_o = {8'h00, a_i | b_i};
      cpf_pkg::ALU_EOR: res_o = {8'h00, a_i ^ b_i};
      cpf_pkg::ALU_ADIW: begin
        res_o = sum16[15:0];
        flags_o[cpf_pkg::F_C] = sum16[16];
        flags_o[cpf_pkg::F_V] = ~b_i[7] & sum16[15];
      end
      cpf_pkg::ALU_PASS: res_o = {8'h00, b_i};
      default: begin
        res_o = mres;
        flags_o[cpf_pkg::F_C] = prod[15];
        flags_o[cpf_pkg::F_Z] = mres == 16'h0000;
      end
    endcase
    r7 = wide ? res_o[15] : res_o[7];
    // Logic ops clear overflow; sign flags follow the result width
    if (op_i == cpf_pkg::ALU_AND || op_i == cpf_pkg::ALU_OR || op_i == cpf_pkg::ALU_EOR) begin
      flags_o[cpf_pkg::F_V] = 1'b0;
    end
    if (op_i <= cpf_pkg::ALU_EOR || wide) begin
      flags_o[cpf_pkg::F_N] = r7;
      flags_o[cpf_pkg::F_Z] = wide ? res_o == 16'h0000 : res_o[7:0] == 8'h00;
      flags_o[cpf_pkg::F_S] = r7 ^ flags_o[cpf_pkg::F_V];
    end
  end
endmodule // cpf_alu
`default_nettype wire

// [verilog/cpf_core.sv]
`timescale 1ns/100ps
`default_nettype none
module cpf_core (
  // Clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_N_I,
  // Program flash
  output logic      [15:0] PMEM_ADDR_O,
  input  wire logic [15:0] PMEM_DATA_I,
  output logic             FLASH_WE_O,
  output logic      [15:0] FLASH_WADDR_O,
  output logic      [15:0] FLASH_WDATA_O,
  output logic             SPM_DENIED_O,
  // Section locks: 00 open, 01 no write, 1x no write and no read from code in another section
  input  wire logic [1:0]  LOCK_APP_I,
  input  wire logic [1:0]  LOCK_TBL_I,
  input  wire logic [1:0]  LOCK_BOOT_I,
  // Data SRAM and I/O space
  output logic      [15:0] DMEM_ADDR_O,
  output logic      [7:0]  DMEM_WDATA_O,
  output logic             DMEM_WE_O,
  output logic             DMEM_RE_O,
  input  wire logic [7:0]  DMEM_RDATA_I,
  // Interrupt
  input  wire logic        IRQ_REQ_I,
  input  wire logic [15:0] IRQ_VEC_I,
  output logic             IRQ_ACK_O
);
  typedef enum logic [3:0] {ST_EXEC, ST_OPND, ST_PUSH_HI, ST_POP_A, ST_POP_B, ST_POP_C,
                            ST_LD_A, ST_LD_B, ST_LPM_A, ST_LPM_B} cpf_state_e;

  // Lock that covers a word address
  function automatic logic [1:0] lock_for(input logic [15:0] a, input logic [1:0] la,
                                          input logic [1:0] lt, input logic [1:0] lb);
    if (a >= cpf_pkg::BOOT_LO) lock_for = lb;
    else if (a >= cpf_pkg::TBL_LO) lock_for = lt;
    else lock_for = la;
  endfunction

  // Section index: 0 application, 1 table, 2 boot
  function automatic logic [1:0] sect_of(input logic [15:0] a);
    if (a >= cpf_pkg::BOOT_LO && a <= cpf_pkg::BOOT_HI) sect_of = 2'h2;
    else if (a >= cpf_pkg::TBL_LO && a < cpf_pkg::BOOT_LO) sect_of = 2'h1;
    else sect_of = 2'h0;
  endfunction

  cpf_state_e state;
  cpf_state_e next_state;
  logic [15:0] pc;
  logic [15:0] next_pc;
  logic [15:0] iaddr;
  logic        fv;
  logic        next_fv;
  logic [15:0] sp;
  logic [15:0] next_sp;
  logic [7:0]  sreg;
  logic [7:0]  next_sreg;
  logic [15:0] ret;
  logic [15:0] next_ret;
  logic [15:0] tgt;
  logic [15:0] next_tgt;
  logic [7:0]  tmp;
  logic [7:0]  next_tmp;
  logic [4:0]  ld_dst;
  logic [4:0]  next_ld_dst;
  logic        flag_a;
  logic        next_flag_a;
  logic        flag_b;
  logic        next_flag_b;
  logic [15:0] next_dm_addr;
  logic [7:0]  next_dm_wdata;
  logic        next_dm_we;
  logic        next_dm_re;
  logic        next_fl_we;
  logic        next_spm_deny;
  logic        next_irq_ack;

  logic [7:0]  a_val;
  logic [7:0]  b_val;
  logic [15:0] x_val;
  logic [15:0] y_val;
  logic [15:0] z_val;
  // Decode of the word on the flash data bus
  logic [15:0] iw;
  logic [3:0]  opc;
  logic [3:0]  fn;
  logic [5:0]  io;
  logic        imm_fmt;
  logic [4:0]  ra;
  logic [4:0]  rb;
  logic [15:0] ptr;
  logic [15:0] br_tgt;
  logic        irq_take;
  logic        spm_ok;
  logic        lpm_blk;
  assign iw      = PMEM_DATA_I;
  assign opc     = iw[15:12];
  assign fn      = iw[3:0];
  assign io      = iw[10:5];
  assign imm_fmt = opc >= cpf_pkg::OP_LDI && opc <= cpf_pkg::OP_ORI;
  assign ra = opc == cpf_pkg::OP_LDST ? iw[8:4] :
              opc == cpf_pkg::OP_INOUT ? iw[4:0] :
              opc == cpf_pkg::OP_ADIW ? {2'b11, iw[7:6], 1'b0} :
              opc == cpf_pkg::OP_MISC ? 5'h01 :
              imm_fmt ? {1'b1, iw[11:8]} : iw[11:7];
  assign rb = opc == cpf_pkg::OP_ADIW ? {2'b11, iw[7:6], 1'b1} :
              opc == cpf_pkg::OP_MISC ? 5'h00 : iw[6:2];
  assign ptr = iw[10:9] == 2'h0 ? x_val : iw[10:9] == 2'h1 ? y_val : z_val;
  assign br_tgt   = iaddr + 16'h0001 + {{10{iw[5]}}, iw[5:0]};
  assign irq_take = IRQ_REQ_I && sreg[cpf_pkg::F_I];
  assign spm_ok   = sect_of(iaddr) == 2'h2 && lock_for(z_val, LOCK_APP_I, LOCK_TBL_I, LOCK_BOOT_I) == 2'h0;
  assign lpm_blk  = lock_for({1'b0, z_val[15:1]}, LOCK_APP_I, LOCK_TBL_I, LOCK_BOOT_I) >= 2'h2
                    && sect_of({1'b0, z_val[15:1]}) != sect_of(iaddr);

  // Register file and ALU
  logic        rf_we;
  logic [4:0]  rf_waddr;
  logic [7:0]  rf_wdata;
  logic        rf_pwe;
  logic [3:0]  rf_paddr;
  cpf_pkg::cpf_alu_e alu_op;
  logic [7:0]  alu_b;
  logic [15:0] alu_res;
  logic [7:0]  alu_flags;

  cpf_regfile u_regfile (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .ra_i    (ra),
    .rb_i    (rb),
    .a_o     (a_val),
    .b_o     (b_val),
    .x_o     (x_val),
    .y_o     (y_val),
    .z_o     (z_val),
    .we_i    (rf_we),
    .waddr_i (rf_waddr),
    .wdata_i (rf_wdata),
    .pwe_i   (rf_pwe),
    .paddr_i (rf_paddr),
    .pdata_i (alu_res)
  );

  cpf_alu u_alu (
    .op_i    (alu_op),
    .a_i     (a_val),
    .b_i     (alu_b),
    .k_i     (iw[5:0]),
    .flags_i (sreg),
    .res_o   (alu_res),
    .flags_o (alu_flags)
  );

  // Operation select for the ALU
  always_comb begin
    alu_op = cpf_pkg::ALU_PASS;
    alu_b  = imm_fmt ? iw[7:0] : b_val;
    case (opc)
      4'h1:              alu_op = cpf_pkg::ALU_ADD;
      4'h2:              alu_op = cpf_pkg::ALU_SUB;
      4'h3:              alu_op = cpf_pkg::ALU_AND;
      4'h4:              alu_op = cpf_pkg::ALU_OR;
      4'h5:              alu_op = cpf_pkg::ALU_EOR;
      cpf_pkg::OP_SUBI:  alu_op = cpf_pkg::ALU_SUB;
      cpf_pkg::OP_ANDI:  alu_op = cpf_pkg::ALU_AND;
      cpf_pkg::OP_ORI:   alu_op = cpf_pkg::ALU_OR;
      cpf_pkg::OP_ADIW:  alu_op = cpf_pkg::ALU_ADIW;
      cpf_pkg::OP_MUL: begin
        alu_op = iw[1] ? (iw[0] ? cpf_pkg::ALU_FMULS : cpf_pkg::ALU_FMUL)
                       : (iw[0] ? cpf_pkg::ALU_MULS : cpf_pkg::ALU_MULU);
      end
      default:           alu_op = cpf_pkg::ALU_PASS;
    endcase
  end

  // Sequencer
  always_comb begin
    next_state    = state;
    next_pc       = pc;
    next_fv       = 1'b1;
    next_sp       = sp;
    next_sreg     = sreg;
    next_ret      = ret;
    next_tgt      = tgt;
    next_tmp      = tmp;
    next_ld_dst   = ld_dst;
    next_flag_a   = flag_a;
    next_flag_b   = flag_b;
    next_dm_addr  = DMEM_ADDR_O;
    next_dm_wdata = DMEM_WDATA_O;
    next_dm_we    = 1'b0;
    next_dm_re    = 1'b0;
    next_fl_we    = 1'b0;
    next_spm_deny = 1'b0;
    next_irq_ack  = 1'b0;
    rf_we         = 1'b0;
    rf_waddr      = ra;
    rf_wdata      = alu_res[7:0];
    rf_pwe        = 1'b0;
    rf_paddr      = 4'h0;
    case (state)
      ST_EXEC: begin
        if (!fv) begin
          next_pc = pc + 16'h0001;
        end else if (irq_take) begin
          next_ret  = iaddr;
          next_tgt  = IRQ_VEC_I;
          next_sreg[cpf_pkg::F_I] = 1'b0;
          next_irq_ack  = 1'b1;
          next_dm_addr  = sp;
          next_dm_wdata = iaddr[7:0];
          next_dm_we    = 1'b1;
          next_sp       = sp - 16'h0001;
          next_state    = ST_PUSH_HI;
        end else begin
          next_pc = pc + 16'h0001;
          case (opc)
            cpf_pkg::OP_MISC: begin
              if (fn == cpf_pkg::FN_RET || fn == cpf_pkg::FN_RETI) begin
                next_sreg[cpf_pkg::F_I] = sreg[cpf_pkg::F_I] | (fn == cpf_pkg::FN_RETI);
                next_dm_addr = sp + 16'h0001;
                next_dm_re   = 1'b1;
                next_sp      = sp + 16'h0001;
                next_pc      = pc;
                next_state   = ST_POP_A;
              end else if (fn == cpf_pkg::FN_SPM) begin
                next_fl_we    = spm_ok;
                next_spm_deny = !spm_ok;
              end else if (fn == cpf_pkg::FN_LPM) begin
                next_tgt    = pc;
                next_pc     = {1'b0, z_val[15:1]};
                next_flag_a = z_val[0];
                next_flag_b = lpm_blk;
                next_state  = ST_LPM_A;
              end else if (fn == cpf_pkg::FN_SEI || fn == cpf_pkg::FN_CLI) begin
                next_sreg[cpf_pkg::F_I] = fn == cpf_pkg::FN_SEI;
              end
            end
            cpf_pkg::OP_LDST: begin
              next_dm_addr  = ptr;
              next_dm_wdata = a_val;
              next_dm_we    = iw[11];
              next_dm_re    = !iw[11];
              next_ld_dst   = iw[8:4];
              if (!iw[11]) begin
                next_pc    = pc;
                next_state = ST_LD_A;
              end
            end
            cpf_pkg::OP_INOUT: begin
              rf_we = !iw[11] && (io == cpf_pkg::IO_SPL || io == cpf_pkg::IO_SPH || io == cpf_pkg::IO_SREG);
              rf_wdata = io == cpf_pkg::IO_SPL ? sp[7:0] : io == cpf_pkg::IO_SPH ? tmp : sreg;
              if (iw[11] && io == cpf_pkg::IO_SPL) next_tmp = a_val;
              else if (iw[11] && io == cpf_pkg::IO_SPH) next_sp = {a_val, tmp};
              else if (iw[11] && io == cpf_pkg::IO_SREG) next_sreg = a_val;
              else if (!iw[11] && io == cpf_pkg::IO_SPL) next_tmp = sp[15:8];
              else if (!rf_we) begin
                next_dm_addr  = {10'h000, io};
                next_dm_wdata = a_val;
                next_dm_we    = iw[11];
                next_dm_re    = !iw[11];
                next_ld_dst   = iw[4:0];
                if (!iw[11]) begin
                  next_pc    = pc;
                  next_state = ST_LD_A;
                end
              end
            end
            cpf_pkg::OP_FLOW: begin
              if (iw[11:10] == cpf_pkg::FL_BR) begin
                if (sreg[iw[8:6]] == iw[9]) begin
                  next_pc = br_tgt;
                  next_fv = 1'b0;
                end
              end else begin
                next_flag_a = iw[11:10] == cpf_pkg::FL_CALL;
                next_state  = ST_OPND;
              end
            end
            default: begin
              rf_we     = opc != cpf_pkg::OP_MUL && opc != cpf_pkg::OP_ADIW;
              rf_pwe    = !rf_we;
              rf_paddr  = opc == cpf_pkg::OP_ADIW ? {2'b11, iw[7:6]} : 4'h0;
              next_sreg = alu_flags;
            end
          endcase
        end
      end
      ST_OPND: begin
        next_tgt = iw;
        if (flag_a) begin
          next_ret      = pc;
          next_dm_addr  = sp;
          next_dm_wdata = pc[7:0];
          next_dm_we    = 1'b1;
          next_sp       = sp - 16'h0001;
          next_state    = ST_PUSH_HI;
        end else begin
          next_pc    = iw;
          next_fv    = 1'b0;
          next_state = ST_EXEC;
        end
      end
      ST_PUSH_HI: begin
        next_dm_addr  = sp;
        next_dm_wdata = ret[15:8];
        next_dm_we    = 1'b1;
        next_sp       = sp - 16'h0001;
        next_pc       = tgt;
        next_fv       = 1'b0;
        next_state    = ST_EXEC;
      end
      ST_POP_A: begin
        next_dm_addr = sp + 16'h0001;
        next_dm_re   = 1'b1;
        next_sp      = sp + 16'h0001;
        next_state   = ST_POP_B;
      end
      ST_POP_B: begin
        next_ret   = {DMEM_RDATA_I, 8'h00};
        next_state = ST_POP_C;
      end
      ST_POP_C: begin
        next_pc    = {ret[15:8], DMEM_RDATA_I};
        next_fv    = 1'b0;
        next_state = ST_EXEC;
      end
      ST_LD_A: next_state = ST_LD_B;
      ST_LD_B: begin
        rf_we      = 1'b1;
        rf_waddr   = ld_dst;
        rf_wdata   = DMEM_RDATA_I;
        next_fv    = 1'b0;
        next_state = ST_EXEC;
      end
      ST_LPM_A: begin
        next_pc    = tgt;
        next_state = ST_LPM_B;
      end
      default: begin
        rf_we      = 1'b1;
        rf_waddr   = 5'h00;
        rf_wdata   = flag_b ? cpf_pkg::LOCKED_READ : flag_a ? iw[15:8] : iw[7:0];
        next_fv    = 1'b0;
        next_state = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      state         <= ST_EXEC;
      PMEM_ADDR_O   <= cpf_pkg::PC_RESET;
      pc            <= cpf_pkg::PC_RESET;
      iaddr         <= cpf_pkg::PC_RESET;
      fv            <= 1'b0;
      sp            <= cpf_pkg::SP_RESET;
      sreg          <= cpf_pkg::SREG_RESET;
      ret           <= 16'h0000;
      tgt           <= 16'h0000;
      tmp           <= 8'h00;
      ld_dst        <= 5'h00;
      flag_a        <= 1'b0;
      flag_b        <= 1'b0;
      DMEM_ADDR_O   <= 16'h0000;
      DMEM_WDATA_O  <= 8'h00;
      DMEM_WE_O     <= 1'b0;
      DMEM_RE_O     <= 1'b0;
      FLASH_WE_O    <= 1'b0;
      FLASH_WADDR_O <= 16'h0000;
      FLASH_WDATA_O <= 16'h0000;
      SPM_DENIED_O  <= 1'b0;
      IRQ_ACK_O     <= 1'b0;
    end else begin
      state         <= next_state;
      PMEM_ADDR_O   <= next_pc;
      pc            <= next_pc;
      iaddr         <= pc;
      fv            <= next_fv;
      sp            <= next_sp;
      sreg          <= next_sreg;
      ret           <= next_ret;
      tgt           <= next_tgt;
      tmp           <= next_tmp;
      ld_dst        <= next_ld_dst;
      flag_a        <= next_flag_a;
      flag_b        <= next_flag_b;
      DMEM_ADDR_O   <= next_dm_addr;
      DMEM_WDATA_O  <= next_dm_wdata;
      DMEM_WE_O     <= next_dm_we;
      DMEM_RE_O     <= next_dm_re;
      FLASH_WE_O    <= next_fl_we;
      FLASH_WADDR_O <= z_val;
      FLASH_WDATA_O <= {a_val, b_val};
      SPM_DENIED_O  <= next_spm_deny;
      IRQ_ACK_O     <= next_irq_ack;
    end
  end
endmodule // cpf_core
`default_nettype wire

// [sim/cpf_core_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module cpf_core_monitor (
  // Clock, reset and locks
  input wire logic        CORE_CLK_I,
  input wire logic        RST_N_I,
  input wire logic [1:0]  LOCK_APP_I,
  input wire logic [1:0]  LOCK_TBL_I,
  // Core outputs
  input wire logic [15:0] PMEM_ADDR_O,
  input wire logic        FLASH_WE_O,
  input wire logic [15:0] FLASH_WADDR_O,
  input wire logic        SPM_DENIED_O,
  input wire logic [15:0] DMEM_ADDR_O,
  input wire logic        DMEM_WE_O,
  input wire logic        IRQ_ACK_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_start; PMEM_ADDR_O == 16'h0000 ##1 PMEM_ADDR_O == 16'h0001; endsequence
  sequence s_push; DMEM_WE_O ##1 DMEM_WE_O && DMEM_ADDR_O == $past(DMEM_ADDR_O) - 16'h0001; endsequence
  property p_pc_start; $rose(RST_N_I) |-> s_start; endproperty
  a_pc_start: assert property (p_pc_start) else $error("bad fetch start");
  property p_idle; $rose(RST_N_I) |-> !DMEM_WE_O && !FLASH_WE_O && !IRQ_ACK_O; endproperty
  a_idle: assert property (p_idle) else $error("strobe after reset");
  property p_app_lock; FLASH_WE_O && FLASH_WADDR_O < cpf_pkg::TBL_LO |-> LOCK_APP_I == 2'h0; endproperty
  a_app_lock: assert property (p_app_lock) else $error("app write");
  property p_tbl_lock; FLASH_WE_O && FLASH_WADDR_O >= cpf_pkg::TBL_LO && FLASH_WADDR_O < cpf_pkg::BOOT_LO
    |-> LOCK_TBL_I == 2'h0; endproperty
  a_tbl_lock: assert property (p_tbl_lock) else $error("table write");
  property p_we_den; !(FLASH_WE_O && SPM_DENIED_O); endproperty
  a_we_den: assert property (p_we_den) else $error("write and refusal");
  property p_boot; FLASH_WE_O |-> $past(PMEM_ADDR_O, 2) >= cpf_pkg::BOOT_LO
    && $past(PMEM_ADDR_O, 2) <= cpf_pkg::BOOT_HI; endproperty
  a_boot: assert property (p_boot) else $error("write outside boot");
  property p_irq_push; IRQ_ACK_O |-> s_push; endproperty
  a_irq_push: assert property (p_irq_push) else $error("bad push");
  property p_irq_once; IRQ_ACK_O |=> (!IRQ_ACK_O) [*3]; endproperty
  a_irq_once: assert property (p_irq_once) else $error("repeated entry");
endmodule // cpf_core_monitor
bind cpf_core cpf_core_monitor cpf_core_monitor_inst (.CORE_CLK_I, .RST_N_I, .LOCK_APP_I, .LOCK_TBL_I,
  .PMEM_ADDR_O, .FLASH_WE_O, .FLASH_WADDR_O, .SPM_DENIED_O, .DMEM_ADDR_O, .DMEM_WE_O, .IRQ_ACK_O);
`default_nettype wire

// [sim/cpf_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module cpf_mem_model (
  // Flash port
  input  wire logic        clk_i,
  input  wire logic [15:0] pa_i,
  output logic      [15:0] pd_o,
  input  wire logic        fwe_i,
  input  wire logic [15:0] fwa_i,
  input  wire logic [15:0] fwd_i,
  // Data port
  input  wire logic [15:0] da_i,
  input  wire logic [7:0]  dwd_i,
  input  wire logic        dwe_i,
  input  wire logic        dre_i,
  output logic      [7:0]  drd_o
);
  logic [15:0] flash [0:65535];
  logic [7:0]  sram  [0:65535];
  initial drd_o = 8'h5A;
  // Read data toggles when not read
  always @(posedge clk_i) begin
    pd_o <= flash[pa_i];
    drd_o <= dre_i ? sram[da_i] : ~drd_o;
    if (fwe_i) flash[fwa_i] <= fwd_i;
    if (dwe_i) sram[da_i] <= dwd_i;
  end
endmodule // cpf_mem_model
`default_nettype wire

// [sim/cpu_core_program_flow_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module cpu_core_program_flow_bench;
  typedef struct {logic [15:0] op; logic [4:0] src; logic [7:0] exp;} cpf_row_s;
  cpf_row_s rows [12] = '{'{16'h1844, 5'd16, 8'hFF}, '{16'h2844, 5'd16, 8'h8B}, '{16'h3844, 5'd16, 8'h00},
                          '{16'h4844, 5'd16, 8'hFF}, '{16'h5844, 5'd16, 8'hFF}, '{16'h7844, 5'd0, 8'hA2},
                          '{16'h7845, 5'd1, 8'hF2}, '{16'h7846, 5'd1, 8'h59}, '{16'h7847, 5'd1, 8'hE5},
                          '{16'h2844, 5'd2, 8'h34}, '{16'h3844, 5'd2, 8'h02}, '{16'hC03F, 5'd24, 8'h3F}};
  logic        clk, rst_n, irq, fwe, den, dwe, dre, ack, s_we, s_den, s_ack;
  logic [1:0]  lk_app, lk_tbl, lk_boot;
  logic [15:0] pa, pd, fwa, fwd, da;
  logic [7:0]  dwd, drd;
  int          miscompares = 0;
  int          checks_done = 0;
  cpf_core cpf_core_inst (.CORE_CLK_I(clk), .RST_N_I(rst_n), .PMEM_ADDR_O(pa), .PMEM_DATA_I(pd),
    .FLASH_WE_O(fwe), .FLASH_WADDR_O(fwa), .FLASH_WDATA_O(fwd), .SPM_DENIED_O(den), .LOCK_APP_I(lk_app),
    .LOCK_TBL_I(lk_tbl), .LOCK_BOOT_I(lk_boot), .DMEM_ADDR_O(da), .DMEM_WDATA_O(dwd), .DMEM_WE_O(dwe),
    .DMEM_RE_O(dre), .DMEM_RDATA_I(drd), .IRQ_REQ_I(irq), .IRQ_VEC_I(16'h0100), .IRQ_ACK_O(ack));
  cpf_mem_model cpf_mem_model_inst (.clk_i(clk), .pa_i(pa), .pd_o(pd), .fwe_i(fwe), .fwa_i(fwa),
    .fwd_i(fwd), .da_i(da), .dwd_i(dwd), .dwe_i(dwe), .dre_i(dre), .drd_o(drd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    s_we <= s_we | fwe;
    s_den <= s_den | den;
    s_ack <= s_ack | ack;
  end
  task automatic close_out;
    if (miscompares == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic load(logic [15:0] a, logic [15:0] w [$]);
    foreach (w[i]) cpf_mem_model_inst.flash[a + 16'(i)] = w[i];
  endtask
  task automatic restart(int n);
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    {s_we, s_den, s_ack} = 3'h0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Jump into boot, load the upper pointer byte, then store to flash
  task automatic spm_case(logic [7:0] zhi, logic [1:0] app, logic [1:0] tbl, logic we);
    load(16'h0000, '{16'hF000, 16'h8000});
    load(16'h8000, '{{8'h8F, zhi}, 16'h0003, 16'hF000, 16'h8002});
    lk_app = app;
    lk_tbl = tbl;
    restart(20);
    check("flash write", 16'(we), 16'(s_we));
    check("write refused", 16'(!we), 16'(s_den));
  endtask
  initial begin
    rst_n = 1'b0;
    irq = 1'b0;
    lk_app = 2'h0;
    lk_tbl = 2'h0;
    lk_boot = 2'h0;
    for (int i = 0; i < 65536; i++) cpf_mem_model_inst.flash[i] = 16'h0000;
    // Operand pair, operation, status copied into r2, store, park
    foreach (rows[i]) begin
      load(16'h0000, '{16'h80C5, 16'h813A, rows[i].op, 16'hE7E2, {7'h6C, rows[i].src, 4'h0}, 16'hF000, 16'h0005});
      cpf_mem_model_inst.sram[0] = 8'hEE;
      restart(20);
      check("stored result", 16'(rows[i].exp), 16'(cpf_mem_model_inst.sram[0]));
    end
    load(16'h0000, '{16'h0003, 16'hF000, 16'h0001});
    restart(20);
    check("app write refused", 16'h0001, 16'({s_we, s_den}));
    spm_case(8'h00, 2'h0, 2'h0, 1'b1);
    spm_case(8'h00, 2'h1, 2'h0, 1'b0);
    spm_case(8'h78, 2'h0, 2'h1, 1'b0);
    spm_case(8'h78, 2'h1, 2'h0, 1'b1);
    lk_boot = 2'h1;
    spm_case(8'h80, 2'h0, 2'h0, 1'b0);
    lk_boot = 2'h0;
    // Table byte fetched from application code, open then read-locked
    load(16'h0000, '{16'h8FF0, 16'h0004, 16'hD800, 16'hF000, 16'h0003});
    load(16'h7800, '{16'h1234});
    for (int k = 0; k < 2; k++) begin
      lk_tbl = 2'(2 * k);
      restart(20);
      check("table byte", k ? 16'(cpf_pkg::LOCKED_READ) : 16'h0034, 16'(cpf_mem_model_inst.sram[0]));
    end
    load(16'h0000, '{16'h0005, 16'hF000, 16'h0001});
    load(16'h0100, '{16'hF000, 16'h0100});
    cpf_mem_model_inst.sram[16'h2FFE] = 8'hEE;
    restart(10);
    irq = 1'b1;
    repeat (20) @(posedge clk);
    check("irq taken", 16'h0001, 16'(s_ack));
    check("pushed high byte", 16'h0000, 16'(cpf_mem_model_inst.sram[16'h2FFE]));
    // Call, taken branch over one word, return, then store
    load(16'h0000, '{16'hF400, 16'h0010, 16'hD900, 16'hF000, 16'h0003});
    load(16'h0010, '{16'h8077, 16'hF801, 16'h8055, 16'h0001});
    cpf_mem_model_inst.sram[0] = 8'hEE;
    #1 irq = 1'b0;
    restart(30);
    check("value after return", 16'h0077, 16'(cpf_mem_model_inst.sram[0]));
    check("pushed low byte", 16'h0002, 16'(cpf_mem_model_inst.sram[16'h2FFF]));
    close_out;
  end
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    close_out;
  end
endmodule // cpu_core_program_flow_bench
`default_nettype wire
